// [silb_defs.vh]
// register offsets, field positions, reset values and timing counts for the sil block
`ifndef SILB_DEFS_VH
`define SILB_DEFS_VH
`define SILB_ADDR_W 16
`define SILB_OFF_WAKE 16'hfe00
`define SILB_OFF_RSRC 16'hfe01
`define SILB_OFF_BFC 16'hfe03
`define SILB_OFF_PEND_MID 16'hfe05
`define SILB_OFF_PEND_UP 16'hfe06
`define SILB_OFF_CTRL 16'hfe07
`define SILB_BIT_WAKE 1
`define SILB_BIT_BREAK_CLEAR_ENABLE 7
`define SILB_BIT_SHORT 0
`define SILB_BIT_WDDIS 1
`define SILB_RSRC_POR 7
`define SILB_RSRC_PIN 6
`define SILB_RSRC_WDOG 5
`define SILB_RSRC_BADOP 4
`define SILB_RSRC_BADAD 3
`define SILB_RSRC_BROWN 1
`define SILB_RSRC_RESET 8'h80
`define SILB_CTRL_RESET 8'h00
`define SILB_LONG_WAKE 4096
`define SILB_SHORT_WAKE 32
`define SILB_CNT_W 13
`endif

// [silb_core.v]
// system integration unit: pending flags, reset source, break protection, low-power sequencing
`timescale 1ns/1ps
`default_nettype none
`include "silb_defs.vh"
module silb_core #(
    parameter LONG_WAKE = `SILB_LONG_WAKE,
    parameter SHORT_WAKE = `SILB_SHORT_WAKE
) (
    // clock and reset
    input wire mclk,
    input wire reset_n,
    // register port
    input wire [15:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // interrupt and break requests
    input wire [18:7] irq_req,
    input wire break_req,
    // reset causes, sampled at the last cycle of the system reset
    input wire por_event,
    input wire pin_reset,
    input wire wdog_reset,
    input wire bad_opcode_reset,
    input wire bad_fetch_reset,
    input wire bad_fetch_is_opcode,
    input wire brownout_reset,
    // cpu side
    input wire idle_exec,
    input wire halt_exec,
    input wire osc_tick,
    output wire sys_reset,
    output reg clear_imask,
    output reg force_swi,
    output reg stack_start,
    output wire cpu_clk_en,
    output wire periph_clk_en,
    output wire clkgen_out_en,
    output wire wdog_run,
    output wire wdog_enable,
    output wire flag_clear_allow
);

    // ****************************************
    // state codes
    // ****************************************
    localparam ST_RUN = 2'd0;
    localparam ST_IDLE = 2'd1;
    localparam ST_HALT = 2'd2;
    localparam ST_RECOV = 2'd3;
    localparam [31:0] LONG_M1 = LONG_WAKE - 1;
    localparam [31:0] SHORT_M1 = SHORT_WAKE - 1;
    localparam [`SILB_CNT_W-1:0] LONG_CNT = LONG_M1[`SILB_CNT_W-1:0];
    localparam [`SILB_CNT_W-1:0] SHORT_CNT = SHORT_M1[`SILB_CNT_W-1:0];
    localparam [7:0] CTRL_RST = `SILB_CTRL_RESET;

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [`SILB_CNT_W-1:0] recov_cnt_r;
    reg break_wakeup_flag_r;
    reg break_clear_enable_r;
    reg short_wake_delay_select_r;
    reg watchdog_disable_option_r;
    reg [7:0] reset_source_reg_r;
    reg in_break_r;
    reg [7:0] rsrc_capture;
    reg [7:0] rdata_nxt;
    reg wake_by_irq_r;

    wire any_reset;
    wire any_irq;
    wire hit_wake;
    wire hit_rsrc;
    wire hit_bfc;
    wire hit_ctrl;
    wire recov_done;
    wire bad_fetch_valid;
    wire wr_wake;
    wire wr_bfc;
    wire wr_ctrl;
    wire rd_rsrc;
    wire [`SILB_CNT_W-1:0] recov_limit;

    // ****************************************
    // reset request merge
    // ****************************************
    // only an opcode fetch from a bad address counts as a reset cause
    assign bad_fetch_valid = bad_fetch_reset & bad_fetch_is_opcode;
    // every source is simply ORed, none outranks another
    assign any_reset = por_event | pin_reset | wdog_reset | bad_opcode_reset |
                       bad_fetch_valid | brownout_reset;
    assign sys_reset = any_reset;
    assign any_irq = |irq_req;

    assign hit_wake = reg_addr == `SILB_OFF_WAKE;
    assign hit_rsrc = reg_addr == `SILB_OFF_RSRC;
    assign hit_bfc = reg_addr == `SILB_OFF_BFC;
    assign hit_ctrl = reg_addr == `SILB_OFF_CTRL;
    // only these writes are decoded; pending and source registers ignore writes
    assign wr_wake = reg_wr && hit_wake;
    assign wr_bfc = reg_wr && hit_bfc;
    assign wr_ctrl = reg_wr && hit_ctrl;
    assign rd_rsrc = reg_rd && hit_rsrc;
    assign recov_limit = short_wake_delay_select_r ? SHORT_CNT : LONG_CNT;
    assign recov_done = (state_r == ST_RECOV) && (recov_cnt_r == recov_limit);

    // ****************************************
    // clock gating and protection outputs
    // ****************************************
    assign cpu_clk_en = state_r == ST_RUN;
    assign periph_clk_en = (state_r == ST_RUN) || (state_r == ST_IDLE);
    assign clkgen_out_en = periph_clk_en;
    assign wdog_enable = ~watchdog_disable_option_r;
    assign wdog_run = wdog_enable && periph_clk_en;
    // peripheral clear strobes are gated while in break unless enabled;
    // gating both steps of a two-step clear keeps such flags intact
    // a clear done with the enable set is a real clear, never undone
    assign flag_clear_allow = ~in_break_r | break_clear_enable_r;

    // ****************************************
    // low-power state machine
    // ****************************************
    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN:
            begin
                if (halt_exec)
                    state_nxt = ST_HALT;
                else if (idle_exec)
                    state_nxt = ST_IDLE;
            end
            ST_IDLE:
            begin
                if (break_req || any_irq)
                    state_nxt = ST_RUN;
            end
            ST_HALT:
            begin
                if (break_req)
                    state_nxt = ST_RUN;
                else if (any_irq)
                    state_nxt = ST_RECOV;
            end
            ST_RECOV:
            begin
                if (break_req)
                    state_nxt = ST_RUN;
                else if (recov_done)
                    state_nxt = ST_RUN;
            end
            default:
                state_nxt = ST_RUN;
        endcase
    end

    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r <= ST_RUN;
            recov_cnt_r <= {`SILB_CNT_W{1'b0}};
            clear_imask <= 1'b0;
            force_swi <= 1'b0;
            stack_start <= 1'b0;
            wake_by_irq_r <= 1'b0;
        end
        else if (any_reset)
        begin
            state_r <= ST_RUN;
            recov_cnt_r <= {`SILB_CNT_W{1'b0}};
            clear_imask <= 1'b0;
            force_swi <= 1'b0;
            stack_start <= 1'b0;
            wake_by_irq_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            clear_imask <= (state_r == ST_RUN) && (idle_exec || halt_exec);
            force_swi <= break_req;
            // stacking one cycle after an idle wake
            wake_by_irq_r <= (state_r == ST_IDLE) && any_irq && !break_req;
            stack_start <= wake_by_irq_r || recov_done;
            if (state_r != ST_RECOV)
                recov_cnt_r <= {`SILB_CNT_W{1'b0}};
            else if (osc_tick && !recov_done)
                recov_cnt_r <= recov_cnt_r + 1'b1;
        end
    end

    // ****************************************
    // break state and break wake flag
    // ****************************************
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            in_break_r <= 1'b0;
            break_wakeup_flag_r <= 1'b0;
        end
        else
        begin
            // break entry wins over the end-of-service write
            if (break_req)
                in_break_r <= 1'b1;
            else if (wr_wake)
                in_break_r <= 1'b0;
            // break wake flag: set wins over software clear
            if (any_reset)
                break_wakeup_flag_r <= 1'b0;
            else if (break_req && (state_r != ST_RUN))
                break_wakeup_flag_r <= 1'b1;
            else if (wr_wake && !reg_wdata[`SILB_BIT_WAKE])
                break_wakeup_flag_r <= 1'b0;
        end
    end

    // ****************************************
    // break flag control
    // ****************************************
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            break_clear_enable_r <= 1'b0;
        else if (any_reset)
            break_clear_enable_r <= 1'b0;
        else if (wr_bfc)
            break_clear_enable_r <= reg_wdata[`SILB_BIT_BREAK_CLEAR_ENABLE];
    end

    // ****************************************
    // wake delay and watchdog options
    // ****************************************
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            short_wake_delay_select_r <= CTRL_RST[`SILB_BIT_SHORT];
            watchdog_disable_option_r <= CTRL_RST[`SILB_BIT_WDDIS];
        end
        else if (wr_ctrl)
        begin
            short_wake_delay_select_r <= reg_wdata[`SILB_BIT_SHORT];
            watchdog_disable_option_r <= reg_wdata[`SILB_BIT_WDDIS];
        end
    end

    // ****************************************
    // reset source capture
    // ****************************************
    // power-on alone sets the top flag; bits 2 and 0 stay zero
    always @*
    begin
        rsrc_capture = 8'h00;
        if (por_event)
            rsrc_capture = `SILB_RSRC_RESET;
        else
        begin
            rsrc_capture[`SILB_RSRC_PIN] = pin_reset;
            rsrc_capture[`SILB_RSRC_WDOG] = wdog_reset;
            rsrc_capture[`SILB_RSRC_BADOP] = bad_opcode_reset;
            rsrc_capture[`SILB_RSRC_BADAD] = bad_fetch_valid;
            rsrc_capture[`SILB_RSRC_BROWN] = brownout_reset;
        end
    end

    // capture wins over the read clear
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            reset_source_reg_r <= `SILB_RSRC_RESET;
        else if (any_reset)
            reset_source_reg_r <= rsrc_capture;
        else if (rd_rsrc)
            reset_source_reg_r <= 8'h00;
    end

    // ****************************************
    // read data
    // ****************************************
    // unmapped addresses and idle cycles read zero
    always @*
    begin
        rdata_nxt = 8'h00;
        if (reg_rd)
        begin
            case (reg_addr)
                `SILB_OFF_WAKE:
                    rdata_nxt[`SILB_BIT_WAKE] = break_wakeup_flag_r;
                `SILB_OFF_RSRC:
                    rdata_nxt = reset_source_reg_r;
                `SILB_OFF_BFC:
                    rdata_nxt[`SILB_BIT_BREAK_CLEAR_ENABLE] = break_clear_enable_r;
                `SILB_OFF_PEND_MID:
                    rdata_nxt = irq_req[14:7];
                `SILB_OFF_PEND_UP:
                    rdata_nxt = {4'h0, irq_req[18:15]};
                `SILB_OFF_CTRL:
                begin
                    rdata_nxt[`SILB_BIT_SHORT] = short_wake_delay_select_r;
                    rdata_nxt[`SILB_BIT_WDDIS] = watchdog_disable_option_r;
                end
                default:
                    rdata_nxt = 8'h00;
            endcase
        end
    end

    // read data stands for the one cycle after the strobe
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= rdata_nxt;
    end

endmodule // silb_core
`default_nettype wire

// [silb_assertions.sv]
// port checker for the sil block
`timescale 1ns/1ps
`default_nettype none
// ********
// checker
// ********
module silb_checker (
    // clock and reset
    input wire mclk,
    input wire reset_n,
    // register port
    input wire [15:0] reg_addr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    // requests
    input wire [18:7] irq_req,
    input wire break_req,
    input wire pin_reset,
    input wire idle_exec,
    input wire halt_exec,
    // cpu side
    input wire sys_reset,
    input wire clear_imask,
    input wire force_swi,
    input wire stack_start,
    input wire cpu_clk_en,
    input wire periph_clk_en,
    input wire clkgen_out_en
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    wire go = !sys_reset && !break_req && cpu_clk_en;
    imask_clear_a: assert property (go && (idle_exec || halt_exec) |=> clear_imask)
        else $error("mask not cleared");
    halt_clocks_a: assert property (go && halt_exec |=> !clkgen_out_en && !periph_clk_en)
        else $error("halt clocks run");
    idle_clocks_a: assert property (go && idle_exec && !halt_exec |=> periph_clk_en && !cpu_clk_en)
        else $error("idle clocks wrong");
    idle_wake_a: assert property (!cpu_clk_en && periph_clk_en && |irq_req && !sys_reset && !break_req
        |=> cpu_clk_en ##1 stack_start)
        else $error("idle wake late");
    swi_force_a: assert property (!sys_reset && break_req |=> force_swi)
        else $error("no swi");
    stack_run_a: assert property (stack_start |-> cpu_clk_en)
        else $error("stacking while stopped");
    pend_mid_a: assert property (reg_rd && reg_addr == 16'hfe05 |=> reg_rdata == $past(irq_req[14:7]))
        else $error("mid pending wrong");
    pend_up_a: assert property (reg_rd && reg_addr == 16'hfe06
        |=> reg_rdata == {4'h0, $past(irq_req[18:15])})
        else $error("upper pending wrong");
    pin_reset_a: assert property (pin_reset |-> sys_reset)
        else $error("pin reset lost");
    cover property (go && halt_exec);
    cover property (stack_start && $past(!periph_clk_en));
    cover property (break_req && !periph_clk_en);
endmodule // silb_checker
bind silb_core silb_checker u_chk (.mclk, .reset_n, .reg_addr, .reg_rd, .reg_rdata, .irq_req,
    .break_req, .pin_reset, .idle_exec, .halt_exec, .sys_reset, .clear_imask, .force_swi,
    .stack_start, .cpu_clk_en, .periph_clk_en, .clkgen_out_en);
`default_nettype wire

// [silb_osc_model.sv]
// internal oscillator tick model
`timescale 1ns/1ps
`default_nettype none
module silb_osc_model (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // oscillator tick
    output logic osc_tick
);
    // one tick every second bus cycle
    always_ff @(posedge mclk or negedge reset_n)
        if (!reset_n)
            osc_tick <= 1'b0;
        else
            osc_tick <= !osc_tick;
endmodule // silb_osc_model
`default_nettype wire

// [tb_top.sv]
// self-checking bench for the sil block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int LW = 100;
    localparam int SW = 32;
    logic mclk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, rd_d = 0, break_req = 0;
    logic idle_exec = 0, halt_exec = 0, opc = 0;
    logic [15:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, reg_rdata, exp_q[$];
    logic [18:7] irq_req = 0, v;
    logic [5:0] rs = 0;
    logic sys_reset, clear_imask, force_swi, stack_start, cpu_clk_en, periph_clk_en;
    logic wdog_run, wdog_enable, flag_clear_allow, osc_tick;
    logic [5:0] cv [7] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h04, 6'h02, 6'h01};
    logic [7:0] ev [7] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h00, 8'h02, 8'h80};
    int n_mismatch = 0, checks = 0, cyc = 0;
    always #2 mclk = !mclk;
    silb_osc_model u_osc (.mclk, .reset_n, .osc_tick);
    silb_core #(.LONG_WAKE(LW), .SHORT_WAKE(SW)) DUT (.mclk, .reset_n, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .irq_req, .break_req, .por_event(rs[0]), .pin_reset(rs[5]),
        .wdog_reset(rs[4]), .bad_opcode_reset(rs[3]), .bad_fetch_reset(rs[2]),
        .bad_fetch_is_opcode(opc), .brownout_reset(rs[1]), .idle_exec, .halt_exec, .osc_tick,
        .sys_reset, .clear_imask, .force_swi, .stack_start, .cpu_clk_en, .periph_clk_en,
        .clkgen_out_en(), .wdog_run, .wdog_enable, .flag_clear_allow);
    task chk(input logic [7:0] a, input logic [7:0] e);
        checks++;
        if (a !== e)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e);
        end
    endtask
    task end_of_test;
        $display("mismatches=%0d checks=%0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1;
        exp_q.push_back(e);
        @(posedge mclk);
        reg_rd <= 0;
    endtask
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1;
        @(posedge mclk);
        reg_wr <= 0;
    endtask
    task lp(input bit h, input int n);
        int c;
        @(posedge mclk);
        irq_req <= '0;
        idle_exec <= !h;
        halt_exec <= h;
        @(posedge mclk);
        idle_exec <= 0;
        halt_exec <= 0;
        @(negedge mclk);
        chk(clear_imask, 1);
        chk(periph_clk_en, !h);
        chk(wdog_run, !h);
        if (n == 0)
            return;
        @(posedge mclk);
        irq_req <= 12'h1;
        c = 0;
        while (stack_start !== 1'b1 && c < 1000)
        begin
            @(negedge mclk);
            c++;
        end
        if (h)
            chk(8'(c > 2 * n - 4 && c < 2 * n + 8), 1);
        else
            chk(8'(c == 3), 1);
    endtask
    // read results, oldest note first
    always @(posedge mclk)
        rd_d <= reg_rd;
    always @(negedge mclk)
        if (rd_d)
            chk(reg_rdata, exp_q.pop_front());
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_mismatch++;
            end_of_test;
        end
    end
    initial
    begin
        void'($urandom(32'h9f9e));
        repeat (12) @(posedge mclk);
        reset_n <= 1;
        rd(16'hfe01, 8'h80);
        rd(16'hfe01, 8'h00);
        for (int i = 0; i < 6; i++)
        begin
            v = 12'($urandom);
            @(posedge mclk);
            irq_req <= v;
            wr(16'hfe05, 8'hff);
            rd(16'hfe05, v[14:7]);
            rd(16'hfe06, {4'h0, v[18:15]});
        end
        lp(0, 2);
        wr(16'hfe07, 8'h00);
        lp(1, LW);
        wr(16'hfe07, 8'h01);
        lp(1, SW);
        lp(1, 0);
        @(posedge mclk);
        break_req <= 1;
        @(posedge mclk);
        break_req <= 0;
        @(negedge mclk);
        chk(force_swi, 1);
        chk(flag_clear_allow, 0);
        rd(16'hfe00, 8'h02);
        wr(16'hfe03, 8'hff);
        rd(16'hfe03, 8'h80);
        @(negedge mclk);
        chk(flag_clear_allow, 1);
        wr(16'hfe00, 8'h00);
        rd(16'hfe00, 8'h00);
        wr(16'hfe07, 8'hfe);
        rd(16'hfe07, 8'h02);
        @(negedge mclk);
        chk(wdog_enable, 0);
        chk(wdog_run, 0);
        for (int i = 0; i < 7; i++)
        begin
            @(posedge mclk);
            rs <= cv[i];
            opc <= (i == 3);
            @(negedge mclk);
            chk(sys_reset, 8'(ev[i] != 0));
            @(posedge mclk);
            rs <= 0;
            rd(16'hfe01, ev[i]);
        end
        rd(16'hfe03, 8'h00);
        repeat (3) @(posedge mclk);
        end_of_test;
    end
endmodule // tb_top
`default_nettype wire
